// ---- design/isp_pkg.sv ----
// package: constants and carrier types for the sensor pin interface
package isp_pkg;

  localparam int unsigned PIX_W       = 10;
  localparam int unsigned ADC12_W     = 12;
  localparam int unsigned COLS        = 752;
  localparam int unsigned ROWS        = 480;
  localparam int unsigned HBLANK      = 94;
  localparam int unsigned VBLANK_ROWS = 45;
  localparam int unsigned FRAME_RATE  = 60;
  localparam int unsigned CNT_W       = 11;
  localparam int unsigned SER_W       = 12;
  localparam logic [CNT_W-1:0] CNT_RST = 11'h000;
  localparam logic [PIX_W-1:0] PIX_RST = 10'h000;
  localparam logic [SER_W-1:0] SER_RST = 12'h000;
  localparam logic [3:0]       SER_START = 4'h0;
  localparam logic [3:0]       SER_LAST  = 4'hb;
  localparam logic [3:0]       FRAME_BIT = 4'h1;
  localparam logic [3:0]       LINE_BIT  = 4'h0;

  // scan states, gray coded along idle, wait, active, blank
  typedef enum logic [1:0] {
    ISP_IDLE  = 2'b00,
    ISP_WAIT  = 2'b01,
    ISP_ACT   = 2'b11,
    ISP_BLANK = 2'b10
  } isp_state_e;

  // readout mode bundle
  typedef struct packed {
    logic       snapshot;
    logic       slave;
    logic       stereo_master;
    logic       companding;
    logic [1:0] bin;
    logic       mirror_col;
    logic       mirror_row;
  } isp_mode_s;

  // parallel pixel bundle
  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic             row_valid;
    logic             frame_valid;
  } isp_pix_s;

  // serial merge state on the link clock
  typedef struct packed {
    logic [SER_W-1:0] own_sh;
    logic [SER_W-1:0] slv_sh;
    logic [3:0]       bit_cnt;
    logic             phase;
    logic [2:0]       tog_sync;
    logic             out_bit;
    logic             err;
  } isp_ser_s;

endpackage

// ---- design/isp_serial_merge.sv ----
// module: stereo serial merge on the link shift clock
module isp_serial_merge (
  input  wire logic                   clk_link,
  input  wire logic                   rstn,
  input  wire logic                   ce_link,
  input  wire logic                   merge_en,
  input  wire logic [isp_pkg::PIX_W-1:0] own_word,
  input  wire logic                   word_tog,
  input  wire logic                   slave_bit,
  output logic                        ser_bit,
  output logic                        ser_err
);

  isp_pkg::isp_ser_s st_reg;
  isp_pkg::isp_ser_s st_next;
  logic              load;

  // own words cross as a toggle; word is stable for many link cycles
  assign load = st_reg.tog_sync[2] ^ st_reg.tog_sync[1];

  // interleave own and slave bits, error if slave stream is stuck
  always_comb begin
    st_next = st_reg;
    st_next.tog_sync = {st_reg.tog_sync[1:0], word_tog};
    st_next.slv_sh = {st_reg.slv_sh[isp_pkg::SER_W-2:0], slave_bit};
    if (load) begin
      st_next.own_sh  = {2'b01, own_word};
      st_next.bit_cnt = isp_pkg::SER_START;
      st_next.phase   = 1'b0;
    end else if (st_reg.bit_cnt != isp_pkg::SER_LAST || st_reg.phase) begin
      st_next.phase = merge_en ? ~st_reg.phase : 1'b0;
      if (!merge_en || st_reg.phase) begin
        st_next.own_sh  = {st_reg.own_sh[isp_pkg::SER_W-2:0], 1'b0};
        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
      end
    end
    st_next.out_bit = (merge_en && st_reg.phase) ? slave_bit
                      : st_reg.own_sh[isp_pkg::SER_W-1];
    st_next.err = merge_en && (&st_reg.slv_sh || ~|st_reg.slv_sh);
  end

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (ce_link) begin
      st_reg <= st_next;
    end
  end

  assign ser_bit = st_reg.out_bit;
  assign ser_err = st_reg.err;

endmodule

// ---- design/isp_top.sv ----
// module: pixel interface pin logic of the wide-VGA sensor
module isp_top (
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire logic                      clk_link,
  input  wire isp_pkg::isp_mode_s        mode,
  input  wire logic [isp_pkg::CNT_W-1:0] win_cols,
  input  wire logic [isp_pkg::CNT_W-1:0] win_rows,
  input  wire logic [isp_pkg::ADC12_W-1:0] adc_sample,
  input  wire logic                      exposure_trig,
  input  wire logic                      drive_permit,
  input  wire logic                      standby,
  input  wire logic                      bus_id_select_0,
  input  wire logic                      bus_id_select_1,
  input  wire logic                      row_start_sync_in,
  output logic                           row_start_sync_out,
  output logic                           row_start_sync_oe,
  input  wire logic                      picture_start_sync_in,
  output logic                           picture_start_sync_out,
  output logic                           picture_start_sync_oe,
  output isp_pkg::isp_pix_s              pix_out,
  output logic                           pix_oe,
  output logic                           sample_strobe_out,
  output logic [1:0]                     bus_id,
  output logic                           integrating,
  output logic [isp_pkg::CNT_W-1:0]      pix_col,
  output logic [isp_pkg::CNT_W-1:0]      pix_row,
  output logic                           illuminator_strobe,
  output logic                           error_out,
  input  wire logic                      stereo_serial_in_pos,
  input  wire logic                      stereo_serial_in_neg,
  input  wire logic                      stereo_shift_clk_in_pos,
  input  wire logic                      stereo_shift_clk_in_neg,
  output logic                           serial_stream_out_pos,
  output logic                           serial_stream_out_neg,
  output logic                           serial_strobe_out_pos,
  output logic                           serial_strobe_out_neg
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    isp_pkg::isp_state_e     state;
    logic [2:0]              exp_s;
    logic [2:0]              rsy_s;
    logic [2:0]              psy_s;
    logic [1:0]              err_s;
    logic [isp_pkg::CNT_W-1:0] col;
    logic [isp_pkg::CNT_W-1:0] row;
    logic [1:0]              div;
    isp_pkg::isp_pix_s       pix;
    logic                    rsync;
    logic                    psync;
    logic                    integ;
    logic                    word_tog;
    logic [isp_pkg::PIX_W-1:0] ser_word;
    logic [1:0]              id;
    logic                    id_taken;
  } isp_core_s;

  isp_core_s st_reg;
  isp_core_s st_next;
  logic      exp_rise;
  logic      slave_row;
  logic      slave_pic;
  logic      strobe_en;
  logic      row_end;
  logic      col_end;
  logic [isp_pkg::CNT_W-1:0] col_lim;
  logic [isp_pkg::CNT_W-1:0] row_lim;
  logic [isp_pkg::PIX_W-1:0] word;
  logic [isp_pkg::CNT_W-1:0] eff_col;
  logic [isp_pkg::CNT_W-1:0] eff_row;
  logic      ser_err;
  logic      ser_bit;

  // ************************************************************
  // compander and readout helpers
  // ************************************************************
  // piecewise 12-to-10 compression: full, quarter, then sixteenth slope
  // the top segment must stay inside 0x300..0x3ff or the curve wraps
  function automatic logic [isp_pkg::PIX_W-1:0] compand(
    input logic [isp_pkg::ADC12_W-1:0] s);
    logic [isp_pkg::ADC12_W-1:0] t;
    t = '0;
    if (s < 12'h200) begin
      compand = s[9:0];
    end else if (s < 12'h600) begin
      t = (s - 12'h200) >> 2;
      compand = 10'h200 + t[9:0];
    end else begin
      t = (s - 12'h600) >> 4;
      compand = 10'h300 + t[9:0];
    end
  endfunction

  // window limits, zero means full size; binning shrinks the array
  // zero window gives the full 752 by 480 default frame
  always_comb begin
    col_lim = (win_cols == '0) ? 11'(isp_pkg::COLS) : win_cols;
    row_lim = (win_rows == '0) ? 11'(isp_pkg::ROWS) : win_rows;
    if (mode.bin == 2'h1) begin
      col_lim = col_lim >> 1;
      row_lim = row_lim >> 1;
    end else if (mode.bin == 2'h2) begin
      col_lim = col_lim >> 2;
      row_lim = row_lim >> 2;
    end
  end

  assign eff_col = mode.mirror_col ? col_lim - 11'h1 - st_reg.col
                                   : st_reg.col;
  assign eff_row = mode.mirror_row ? row_lim - 11'h1 - st_reg.row
                                   : st_reg.row;
  // optional companding, else top 10 of 12 bits
  assign word = mode.companding ? compand(adc_sample)
                                : adc_sample[isp_pkg::ADC12_W-1:2];

  // strobe divides by bin factor; only every divided cycle emits a word
  assign strobe_en = (mode.bin == 2'h0) ||
                     (mode.bin == 2'h1 && st_reg.div[0]) ||
                     (st_reg.div == 2'h3);
  assign col_end = st_reg.col == col_lim + 11'(isp_pkg::HBLANK) - 11'h1;
  assign row_end = st_reg.row == row_lim + 11'(isp_pkg::VBLANK_ROWS) - 11'h1;
  assign exp_rise = st_reg.exp_s[2:1] == 2'b01;
  assign slave_row = st_reg.rsy_s[2:1] == 2'b01;
  assign slave_pic = st_reg.psy_s[2:1] == 2'b01;

  // ************************************************************
  // scan sequencer
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.exp_s = {st_reg.exp_s[1:0], exposure_trig};
    st_next.rsy_s = {st_reg.rsy_s[1:0], row_start_sync_in};
    st_next.psy_s = {st_reg.psy_s[1:0], picture_start_sync_in};
    st_next.err_s = {st_reg.err_s[0], ser_err};
    st_next.div = st_reg.div + 2'h1;
    st_next.rsync = 1'b0;
    st_next.psync = 1'b0;
    // address straps taken once after reset release
    if (!st_reg.id_taken) begin
      st_next.id = {bus_id_select_1, bus_id_select_0};
      st_next.id_taken = 1'b1;
    end
    case (st_reg.state)
      isp_pkg::ISP_IDLE: begin
        st_next.pix = '0;
        st_next.col = isp_pkg::CNT_RST;
        st_next.row = isp_pkg::CNT_RST;
        if ((mode.snapshot || mode.slave) && exp_rise) begin
          st_next.integ = 1'b1;
          st_next.state = isp_pkg::ISP_WAIT;
        end else if (!mode.snapshot && !mode.slave) begin
          st_next.state = isp_pkg::ISP_WAIT;
        end
      end
      isp_pkg::ISP_WAIT: begin
        // slave waits for picture sync, master emits it
        if (!mode.slave || slave_pic) begin
          st_next.integ = 1'b0;
          st_next.psync = ~mode.slave;
          st_next.state = isp_pkg::ISP_ACT;
        end
      end
      isp_pkg::ISP_ACT: begin
        if (strobe_en) begin
          // one word per strobe inside window only
          st_next.pix.row_valid = st_reg.row < row_lim &&
                                  st_reg.col < col_lim;
          st_next.pix.frame_valid = st_reg.row < row_lim;
          st_next.pix.data = st_next.pix.row_valid ? word
                                                   : isp_pkg::PIX_RST;
          // one word per row crosses, so it stays put for the link side
          if (st_next.pix.row_valid && st_reg.col == isp_pkg::CNT_RST) begin
            st_next.ser_word = word;
            st_next.word_tog = ~st_reg.word_tog;
          end
          st_next.col = st_reg.col + 11'h1;
          if (col_end) begin
            st_next.col = isp_pkg::CNT_RST;
            st_next.row = st_reg.row + 11'h1;
            // master emits row sync as each active row ends, none before the first row
            st_next.rsync = ~mode.slave;
            if (st_reg.row == row_lim - 11'h1) begin
              st_next.state = isp_pkg::ISP_BLANK;
            end
          end
          // slave restarts its line on row sync
          if (mode.slave && slave_row) begin
            st_next.col = isp_pkg::CNT_RST;
          end
        end
      end
      isp_pkg::ISP_BLANK: begin
        st_next.pix = '0;
        if (strobe_en) begin
          st_next.col = st_reg.col + 11'h1;
          if (col_end) begin
            st_next.col = isp_pkg::CNT_RST;
            st_next.row = st_reg.row + 11'h1;
            if (row_end) begin
              st_next.state = isp_pkg::ISP_IDLE;
            end
          end
        end
      end
      default: st_next.state = isp_pkg::ISP_IDLE;
    endcase
  end

  // asynchronous reset; standby freezes state like ce
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (ce && !standby) begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // stereo serial path
  // ************************************************************
  // merge on the slave shift clock
  isp_serial_merge u_merge (
    .clk_link  (clk_link),
    .rstn      (rstn),
    .ce_link   (~standby),
    .merge_en  (mode.stereo_master),
    .own_word  (st_reg.ser_word),
    .word_tog  (st_reg.word_tog),
    .slave_bit (stereo_serial_in_pos & ~stereo_serial_in_neg),
    .ser_bit   (ser_bit),
    .ser_err   (ser_err)
  );

  // differential serial data and shift clock
  assign serial_stream_out_pos = ser_bit;
  assign serial_stream_out_neg = ~ser_bit;
  assign serial_strobe_out_pos = stereo_shift_clk_in_pos &
                                 ~stereo_shift_clk_in_neg;
  assign serial_strobe_out_neg = ~serial_strobe_out_pos;

  // ************************************************************
  // pin drivers
  // ************************************************************
  // pixel pads driven only with permission
  assign pix_oe = drive_permit;
  assign pix_out = st_reg.pix;
  // strobe low while data changes, rising mid-word
  assign sample_strobe_out = ~clk_sys;
  assign row_start_sync_out = st_reg.rsync;
  assign row_start_sync_oe = ~mode.slave;
  assign picture_start_sync_out = st_reg.psync;
  assign picture_start_sync_oe = ~mode.slave;
  assign bus_id = st_reg.id;
  assign integrating = st_reg.integ;
  assign illuminator_strobe = st_reg.integ;
  assign pix_col = eff_col;
  assign pix_row = eff_row;
  // error pin follows stereo error flag
  assign error_out = st_reg.err_s[1];

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_trig;
    mode.snapshot && !standby && ce && exp_rise &&
    st_reg.state == isp_pkg::ISP_IDLE;
  endsequence

  property p_trig_start;
    @(posedge clk_sys) disable iff (!rstn)
    s_trig |=> integrating;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start integration");

  property p_oe;
    @(posedge clk_sys) disable iff (!rstn)
    pix_oe == drive_permit;
  endproperty
  a_oe: assert property (p_oe)
    else $error("pad enable does not follow permission");

  property p_rv_fv;
    @(posedge clk_sys) disable iff (!rstn)
    pix_out.row_valid |-> pix_out.frame_valid;
  endproperty
  a_rv_fv: assert property (p_rv_fv)
    else $error("row valid without frame valid");

  property p_blank_zero;
    @(posedge clk_sys) disable iff (!rstn)
    !pix_out.row_valid |-> pix_out.data == isp_pkg::PIX_RST;
  endproperty
  a_blank_zero: assert property (p_blank_zero)
    else $error("data not zero in blanking");

  property p_sync_dir;
    @(posedge clk_sys) disable iff (!rstn)
    mode.slave |-> !row_start_sync_oe && !picture_start_sync_oe;
  endproperty
  a_sync_dir: assert property (p_sync_dir)
    else $error("slave drives a sync pin");

  property p_psync_pulse;
    @(posedge clk_sys) disable iff (!rstn)
    picture_start_sync_out && ce && !standby |=> !picture_start_sync_out;
  endproperty
  a_psync_pulse: assert property (p_psync_pulse)
    else $error("picture sync longer than one cycle");

  property p_standby;
    @(posedge clk_sys) disable iff (!rstn)
    standby |=> $stable(st_reg.col) && $stable(st_reg.state);
  endproperty
  a_standby: assert property (p_standby)
    else $error("state moved in standby");

  property p_err;
    @(posedge clk_sys) disable iff (!rstn)
    ce && !standby ##1 ce && !standby |->
      error_out == $past(st_reg.err_s[0]);
  endproperty
  a_err: assert property (p_err)
    else $error("error pin does not track flag");

endmodule

// ---- bench/isp_slave_model.sv ----
// stereo slave model: serial frames on its own shift clock
module isp_slave_model (
  input  wire logic stuck,
  output logic      clk_link,
  output logic      ser_pos,
  output logic      ser_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx;
  logic [9:0] word;
  // *********************************
  // shift clock and frame generator
  // *********************************
  // runs free from time zero; the merge logic resets asynchronously and needs no edges
  initial begin
    clk_link = 1'b0;
    ser_pos  = 1'b0;
    idx      = 4'h0;
    word     = 10'h155;
    #7;
    forever #24 clk_link = ~clk_link;
  end
  // frame of 01 then word msb first, changed on falling edge
  always @(negedge clk_link) begin
    ser_pos <= stuck | (idx < 4'h2 ? idx[0] : word[4'hb - idx]);
    idx     <= (idx == 4'hb) ? 4'h0 : idx + 4'h1;
    if (idx == 4'hb) word <= word + 10'h001;
  end
  assign ser_neg = ~ser_pos;
endmodule

// ---- bench/testbench.sv ----
// testbench: scenario tasks for the sensor pin interface
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // *********
  // signals
  // *********
  logic                      clk_sys, rstn, trig, permit, standby, stuck, ce;
  logic                      led;
  logic [isp_pkg::CNT_W-1:0] col_a, row_a;
  logic                      clk_link, s_pos, s_neg;
  logic [1:0]                sel, bus_id;
  logic [isp_pkg::CNT_W-1:0] win_cols, win_rows;
  logic [11:0]               adc;
  isp_pkg::isp_mode_s        mode;
  isp_pkg::isp_pix_s         pix, snap;
  logic                      rs_out, rs_oe, ps_out, ps_oe, pix_oe;
  logic                      strobe, integ, err_o, so_p, so_n, sc_p, sc_n;
  int                        err_count, compares, cycles;

  // sync pins resolve with a pull-down when nobody drives them
  isp_top i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .clk_link(clk_link),
    .mode(mode), .win_cols(win_cols), .win_rows(win_rows),
    .adc_sample(adc), .exposure_trig(trig), .drive_permit(permit),
    .standby(standby), .bus_id_select_0(sel[0]),
    .bus_id_select_1(sel[1]), .row_start_sync_in(rs_oe & rs_out),
    .row_start_sync_out(rs_out), .row_start_sync_oe(rs_oe),
    .picture_start_sync_in(ps_oe & ps_out),
    .picture_start_sync_out(ps_out), .picture_start_sync_oe(ps_oe),
    .pix_out(pix), .pix_oe(pix_oe), .sample_strobe_out(strobe),
    .bus_id(bus_id), .integrating(integ), .pix_col(col_a),
    .pix_row(row_a), .illuminator_strobe(led), .error_out(err_o),
    .stereo_serial_in_pos(s_pos), .stereo_serial_in_neg(s_neg),
    .stereo_shift_clk_in_pos(clk_link),
    .stereo_shift_clk_in_neg(~clk_link),
    .serial_stream_out_pos(so_p), .serial_stream_out_neg(so_n),
    .serial_strobe_out_pos(sc_p), .serial_strobe_out_neg(sc_n)
  );
  isp_slave_model i_slave (
    .stuck(stuck), .clk_link(clk_link), .ser_pos(s_pos), .ser_neg(s_neg)
  );

  // ***************
  // common tasks
  // ***************
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // waits on a pin level, bounded so a dead output cannot hang us
  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ************
  // scenarios
  // ************
  // defaults and straps after reset
  task automatic t_reset();
    @(negedge clk_sys);
    chk("pix_out", 16'h0, 16'(pix));
    chk("error_out", 16'h0, 16'(err_o));
    chk("syncs", 16'h0, 16'({rs_out, ps_out}));
    chk("bus_id", 16'h2, 16'(bus_id));
    chk("pix_col", 16'h0, 16'(col_a));
    chk("pix_row", 16'h0, 16'(row_a));
  endtask

  task automatic t_pads();
    @(posedge clk_sys) permit <= 1'b0;
    @(negedge clk_sys);
    chk("pix_oe low", 16'h0, 16'(pix_oe));
    chk("strobe high", 16'h1, 16'(strobe));
    @(posedge clk_sys) permit <= 1'b1;
    #1 chk("strobe low", 16'h0, 16'(strobe));
    @(negedge clk_sys);
    chk("pix_oe high", 16'h1, 16'(pix_oe));
  endtask

  // one snapshot frame of a small window
  task automatic t_frame();
    int rv, rows, bad;
    logic prv, inf, hit;
    rv = 0;
    rows = 0;
    bad = 0;
    prv = 0;
    inf = 0;
    hit = 0;
    @(posedge clk_sys) trig <= 1'b1;
    // three edges carry the pulse through the pin synchroniser
    repeat (3) @(posedge clk_sys);
    trig <= 1'b0;
    // watch from here on, the first row follows two edges later
    for (int i = 0; i < 9000; i++) begin
      @(negedge clk_sys);
      if (integ === 1'b1 && led === 1'b1) hit = 1;
      if (pix.row_valid === 1'b1) begin
        rv++;
        if (!prv) rows++;
        if (pix.frame_valid !== 1'b1 || pix.data !== 10'h2ad) bad++;
      end
      prv = (pix.row_valid === 1'b1);
      if (pix.frame_valid === 1'b1) inf = 1;
      else if (inf) break;
    end
    chk("integrating", 16'h1, 16'(hit));
    chk("words", 16'd12, 16'(rv));
    chk("rows", 16'd3, 16'(rows));
    chk("word or flags", 16'h0, 16'(bad));
  endtask

  // sync pins in master and slave mode
  task automatic t_master();
    @(posedge clk_sys) mode <= '0;
    @(negedge clk_sys);
    chk("row sync oe", 16'h1, 16'(rs_oe));
    chk("pic sync oe", 16'h1, 16'(ps_oe));
    wait_hi(ps_out, 6000);
    chk("pic sync", 16'h1, 16'(ps_out));
    @(negedge clk_sys);
    chk("pic sync pulse", 16'h0, 16'(ps_out));
    chk("row after sync", 16'h1, 16'(pix.row_valid));
    wait_hi(rs_out, 300);
    chk("row sync", 16'h1, 16'(rs_out));
    @(posedge clk_sys) mode.slave <= 1'b1;
    @(negedge clk_sys);
    chk("slave oe", 16'h0, 16'({rs_oe, ps_oe}));
    @(posedge clk_sys) mode.slave <= 1'b0;
    mode.companding <= 1'b1;
    // next row start, then its first word is companded
    wait_hi(rs_out, 300);
    @(negedge clk_sys);
    chk("companded", 16'h34b, 16'(pix.data));
    @(posedge clk_sys) mode.companding <= 1'b0;
  endtask

  // standby freezes output, then async reset mid-frame
  task automatic t_standby();
    int bad;
    bad = 0;
    for (int i = 0; i < 6000 && pix.row_valid !== 1'b1; i++)
      @(negedge clk_sys);
    @(posedge clk_sys) standby <= 1'b1;
    @(negedge clk_sys) snap = pix;
    repeat (20) @(negedge clk_sys) if (pix !== snap) bad++;
    chk("standby hold", 16'h0, 16'(bad));
    // clock enable low must freeze the core just as standby does
    @(posedge clk_sys);
    standby <= 1'b0;
    ce <= 1'b0;
    repeat (20) @(negedge clk_sys) if (pix !== snap) bad++;
    chk("ce hold", 16'h0, 16'(bad));
    @(posedge clk_sys) rstn <= 1'b0;
    ce <= 1'b1;
    #1 chk("async reset", 16'h0, 16'(pix));
    // held long enough to span a link clock edge as well
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // merged stream and stuck slave error
  task automatic t_stereo();
    int bad, ones, zeros;
    bad = 0;
    ones = 0;
    zeros = 0;
    @(posedge clk_sys) mode.stereo_master <= 1'b1;
    repeat (400) begin
      @(negedge clk_sys);
      if (so_p !== ~so_n || sc_p !== ~sc_n) bad++;
      if (so_p === 1'b1) ones++;
      if (so_p === 1'b0) zeros++;
    end
    chk("pairs", 16'h0, 16'(bad));
    chk("stream moves", 16'h1, 16'(ones > 0 && zeros > 0));
    chk("no error", 16'h0, 16'(err_o));
    @(posedge clk_sys) stuck <= 1'b1;
    wait_hi(err_o, 800);
    chk("stuck error", 16'h1, 16'(err_o));
    @(posedge clk_sys) stuck <= 1'b0;
  endtask

  // *************
  // run control
  // *************
  // system clock stands in for the supplied master clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // hang guard: the whole sequence needs well under 30000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    trig = 1'b0;
    permit = 1'b1;
    standby = 1'b0;
    stuck = 1'b0;
    ce = 1'b1;
    sel = 2'b10;
    mode = '0;
    mode.snapshot = 1'b1;
    win_cols = 11'h004;
    win_rows = 11'h003;
    adc = 12'hab7;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_pads();
    t_frame();
    t_master();
    t_standby();
    t_stereo();
    print_verdict();
  end
endmodule
